// [core/alarm_pkg.sv]
// shared constants and types of the alarm priority router
package alarm_pkg;

    // ----------------
    // list geometry and record fields
    // ----------------
    localparam int LIST_DEPTH = 1000;
    localparam int IDX_W      = 10;
    localparam int CNT_W      = 11;
    localparam int N_SRC      = 4;
    localparam int SRC_W      = 2;
    localparam int PRIO_W     = 7;
    localparam int CODE_W     = 8;
    localparam int DIGIT_W    = 4;
    localparam int N_DIGIT    = 10;

    // ----------------
    // priority digits and relay slots
    // ----------------
    localparam logic [DIGIT_W-1:0] DIGIT_LOG_ONLY  = 4'h0;
    localparam logic [DIGIT_W-1:0] DIGIT_RELAY_A   = 4'h1;
    localparam logic [DIGIT_W-1:0] DIGIT_RELAY_B   = 4'h2;
    localparam logic [DIGIT_W-1:0] DIGIT_AUX_MIN   = 4'h3;
    localparam logic [DIGIT_W-1:0] DIGIT_AUX_MAX   = 4'h9;
    localparam logic [DIGIT_W-1:0] AUX_DIGIT_RESET = 4'h3;
    localparam int N_RELAY   = 3;
    localparam int SLOT_A    = 0;
    localparam int SLOT_B    = 1;
    localparam int SLOT_AUX  = 2;

    // ----------------
    // timing
    // ----------------
    localparam int CLK_MHZ      = 100;
    localparam int DROP_TIME_MS = 5000;
    localparam int HOLD_TIME_S  = 300;
    localparam longint unsigned DROP_CYCLES_DEF = 64'(DROP_TIME_MS) * 64'(1000) * 64'(CLK_MHZ);
    localparam longint unsigned HOLD_CYCLES_DEF = 64'(HOLD_TIME_S) * 64'(1000000) * 64'(CLK_MHZ);
    localparam int TMR_W = 36;

    typedef enum logic [1:0] {OP_NONE, OP_MARK, OP_COMPACT, OP_CENSUS} sweep_op_t;
    typedef enum logic {AUX_HORN, AUX_PRIO} aux_mode_t;
    localparam aux_mode_t AUX_MODE_RESET = AUX_HORN;

    typedef struct packed {
        logic              resolved;
        logic [SRC_W-1:0]  src;
        logic [PRIO_W-1:0] prio;
        logic [CODE_W-1:0] code;
    } rec_t;

    function automatic logic [DIGIT_W-1:0] digit_of(input logic [PRIO_W-1:0] prio);
        digit_of = DIGIT_W'(prio % PRIO_W'(N_DIGIT));
    endfunction : digit_of

endpackage : alarm_pkg

// [core/list_if.sv]
// carrier between the router and one record list
`timescale 1ns/1ps
`default_nettype none
interface list_if;
    logic                         push;
    alarm_pkg::rec_t              push_rec;
    logic                         start;
    alarm_pkg::sweep_op_t         op;
    logic [alarm_pkg::SRC_W-1:0]  key_src;
    logic [alarm_pkg::CODE_W-1:0] key_code;
    logic                         done;
    logic                         visit;
    alarm_pkg::rec_t              visit_rec;
    logic [alarm_pkg::CNT_W-1:0]  count;
    logic [alarm_pkg::IDX_W-1:0]  rd_idx;
    alarm_pkg::rec_t              rd_rec;

    modport store (input push, push_rec, start, op, key_src, key_code, rd_idx,
                   output done, visit, visit_rec, count, rd_rec);
    modport owner (output push, push_rec, start, op, key_src, key_code, rd_idx,
                   input done, visit, visit_rec, count, rd_rec);
endinterface : list_if
`default_nettype wire

// [core/record_list.sv]
// circular record list with oldest-first sweeps
`timescale 1ns/1ps
`default_nettype none
module record_list (
    input wire logic mclk,
    input wire logic srst,
    list_if.store    lst
);
    import alarm_pkg::*;

    typedef enum logic [1:0] {L_IDLE, L_READ, L_EVAL} lphase_t;
    typedef struct packed {
        logic [IDX_W-1:0]  head;
        logic [CNT_W-1:0]  count;
        lphase_t           phase;
        sweep_op_t         op;
        logic [SRC_W-1:0]  key_src;
        logic [CODE_W-1:0] key_code;
        logic [CNT_W-1:0]  rd_off;
        logic [CNT_W-1:0]  wr_off;
        logic              done;
        logic              visit;
        rec_t              visit_rec;
    } lstate_t;

    lstate_t          s;
    lstate_t          next_s;
    rec_t             mem [LIST_DEPTH];
    rec_t             sweep_q;
    rec_t             rd_q;
    logic             we;
    logic [IDX_W-1:0] waddr;
    rec_t             wdata;

    function automatic logic [IDX_W-1:0] wrap(input logic [IDX_W-1:0] head,
                                              input logic [CNT_W-1:0] off);
        logic [CNT_W:0] sum;
        sum = {2'h0, head} + {1'b0, off};
        if (sum >= (CNT_W+1)'(LIST_DEPTH)) begin
            sum = sum - (CNT_W+1)'(LIST_DEPTH);
        end
        wrap = sum[IDX_W-1:0];
    endfunction : wrap

    always_comb begin
        rec_t r;
        r = sweep_q;
        next_s = s;
        next_s.done = 1'b0;
        next_s.visit = 1'b0;
        we = 1'b0;
        waddr = wrap(s.head, s.count);
        wdata = lst.push_rec;
        if (lst.push) begin
            we = 1'b1;
            if (s.count == CNT_W'(LIST_DEPTH)) begin
                waddr = s.head;  // full: oldest slot is reused [RQ1]
                next_s.head = wrap(s.head, CNT_W'(1));
            end else begin
                next_s.count = s.count + CNT_W'(1);
            end
        end
        case (s.phase)
            L_IDLE: begin
                if (lst.start) begin
                    next_s.op = lst.op;
                    next_s.key_src = lst.key_src;
                    next_s.key_code = lst.key_code;
                    next_s.rd_off = '0;
                    next_s.wr_off = '0;
                    if (s.count == '0) begin
                        next_s.done = 1'b1;
                    end else begin
                        next_s.phase = L_READ;
                    end
                end
            end
            L_READ: begin
                next_s.phase = L_EVAL;
            end
            L_EVAL: begin
                if (s.op == OP_MARK && r.src == s.key_src && r.code == s.key_code) begin
                    r.resolved = 1'b1;
                end
                next_s.visit = 1'b1;
                next_s.visit_rec = r;
                // only resolved entries leave, the rest close up in order [RQ17] [RQ2]
                if (!(s.op == OP_COMPACT && r.resolved)) begin
                    we = 1'b1;
                    waddr = wrap(s.head, s.wr_off);
                    wdata = r;
                    next_s.wr_off = s.wr_off + CNT_W'(1);
                end
                next_s.rd_off = s.rd_off + CNT_W'(1);
                if (s.rd_off + CNT_W'(1) == s.count) begin
                    next_s.phase = L_IDLE;
                    next_s.done = 1'b1;
                    next_s.count = next_s.wr_off;  // [RQ11]
                end else begin
                    next_s.phase = L_READ;
                end
            end
            default: begin
                next_s.phase = L_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // memory kept out of reset: rd_rec shows any slot rd_idx points at, even beyond count
    always_ff @(posedge mclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        sweep_q <= mem[wrap(s.head, s.rd_off)];
        rd_q <= mem[wrap(s.head, {1'b0, lst.rd_idx})];  // index 0 is the oldest [RQ2]
    end

    assign lst.done = s.done;
    assign lst.visit = s.visit;
    assign lst.visit_rec = s.visit_rec;
    assign lst.count = s.count;
    assign lst.rd_rec = rd_q;

endmodule : record_list
`default_nettype wire

// [core/relay_retrigger.sv]
// one alarm relay with drop-and-reenergise retrigger
`timescale 1ns/1ps
`default_nettype none
module relay_retrigger #(
    parameter longint unsigned DROP_CYCLES = alarm_pkg::DROP_CYCLES_DEF,
    parameter longint unsigned HOLD_CYCLES = alarm_pkg::HOLD_CYCLES_DEF
) (
    input  wire logic mclk,
    input  wire logic srst,
    input  wire logic trigger,
    input  wire logic release_req,
    output var  logic relay
);
    import alarm_pkg::*;

    typedef struct packed {
        logic             on;
        logic             dropping;
        logic             pending;
        logic [TMR_W-1:0] since;
        logic [TMR_W-1:0] drop_cnt;
    } rstate_t;

    localparam logic [TMR_W-1:0] HOLD = TMR_W'(HOLD_CYCLES);
    localparam logic [TMR_W-1:0] DROP_LAST = TMR_W'(DROP_CYCLES - 64'(1));

    rstate_t s;
    rstate_t next_s;

    always_comb begin
        next_s = s;
        if (s.since != HOLD) begin
            next_s.since = s.since + TMR_W'(1);
        end
        if (s.dropping) begin
            if (s.drop_cnt == DROP_LAST) begin
                next_s.on = 1'b1;  // re-energise after the drop [RQ15]
                next_s.dropping = 1'b0;
                next_s.since = '0;
            end else begin
                next_s.drop_cnt = s.drop_cnt + TMR_W'(1);
            end
        end else if (trigger && !s.on) begin
            next_s.on = 1'b1;
            next_s.since = '0;
            next_s.pending = 1'b0;
        end else if ((trigger || s.pending) && s.since == HOLD) begin
            next_s.on = 1'b0;  // [RQ15]
            next_s.dropping = 1'b1;
            next_s.drop_cnt = '0;
            next_s.pending = 1'b0;
        end else if (trigger) begin
            next_s.pending = 1'b1;  // too soon: postponed [RQ15]
        end
        if (release_req) begin
            next_s.on = 1'b0;  // [RQ16]
            next_s.dropping = 1'b0;
            next_s.pending = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign relay = s.on;

endmodule : relay_retrigger
`default_nettype wire

// [core/alarm_priority_router.sv]
// alarm priority router: lists, buzzer, horn and alarm relays
`timescale 1ns/1ps
`default_nettype none
// Contract
// RQ1 - each list holds 1000, oldest overwritten
// RQ2 - lists kept oldest first, arrival order
// RQ3 - alarm list pending only; history logs all
// RQ4 - sources send priority none or 0..99
// RQ5 - none priority: no record, no alarm
// RQ6 - digit zero: history only, no alarm
// RQ7 - digit one: both lists, alarms, relay a
// RQ8 - digit two: both lists, alarms, relay b
// RQ9 - digits 3-9 alarm; aux only configured digit
// RQ10 - reset puts aux relay in horn mode
// RQ11 - acknowledge removes entries from alarm list
// RQ12 - history entries never removed
// RQ13 - new alarm sounds buzzer and horn
// RQ14 - mute silences buzzer and horn
// RQ15 - retrigger drops relay 5 s, 5 min spacing
// RQ16 - after mute, release relays without alarms
// RQ17 - only resolved alarms are acknowledgeable
// RQ18 - horn mode aux follows buzzer exactly
// RQ19 - digit is priority mod ten; none flagged
// RQ20 - simultaneous messages taken one at a time
module alarm_priority_router #(
    parameter longint unsigned DROP_CYCLES = alarm_pkg::DROP_CYCLES_DEF,
    parameter longint unsigned HOLD_CYCLES = alarm_pkg::HOLD_CYCLES_DEF
) (
    input  wire logic                          mclk,
    input  wire logic                          srst,
    input  wire logic [alarm_pkg::N_SRC-1:0]   msg_valid,
    input  wire logic [alarm_pkg::N_SRC-1:0]   msg_has_prio,
    input  wire logic [alarm_pkg::N_SRC-1:0][alarm_pkg::PRIO_W-1:0] msg_prio,
    input  wire logic [alarm_pkg::N_SRC-1:0][alarm_pkg::CODE_W-1:0] msg_code,
    output var  logic [alarm_pkg::N_SRC-1:0]   msg_accept,
    input  wire logic                          resolve_valid,
    input  wire logic [alarm_pkg::SRC_W-1:0]   resolve_src,
    input  wire logic [alarm_pkg::CODE_W-1:0]  resolve_code,
    output var  logic                          resolve_accept,
    input  wire logic                          ack_req,
    input  wire logic                          horn_mute,
    input  wire logic                          cfg_write,
    input  wire logic                          cfg_aux_prio_mode,
    input  wire logic [alarm_pkg::DIGIT_W-1:0] cfg_aux_digit,
    input  wire logic [alarm_pkg::IDX_W-1:0]   alarm_rd_idx,
    output var  alarm_pkg::rec_t               alarm_rd_rec,
    output var  logic [alarm_pkg::CNT_W-1:0]   alarm_count,
    input  wire logic [alarm_pkg::IDX_W-1:0]   hist_rd_idx,
    output var  alarm_pkg::rec_t               hist_rd_rec,
    output var  logic [alarm_pkg::CNT_W-1:0]   hist_count,
    output var  logic                          busy,
    output var  logic                          remote_alarm,
    output var  logic                          buzzer,
    output var  logic                          high_alarm_relay_a,
    output var  logic                          high_alarm_relay_b,
    output var  logic                          aux_relay,
    output var  logic                          aux_prio_mode,
    output var  logic [alarm_pkg::DIGIT_W-1:0] aux_decade_select
);
    import alarm_pkg::*;

    // ----------------
    // state
    // ----------------
    typedef enum logic {M_IDLE, M_WAIT} mphase_t;
    typedef struct packed {
        mphase_t             phase;
        sweep_op_t           cur_op;
        logic                pend_ack;
        logic                pend_census;
        logic [N_DIGIT-1:0]  present;
        aux_mode_t           aux_mode;
        logic [DIGIT_W-1:0]  aux_digit;
        logic [N_SRC-1:0]    msg_accept;
        logic                resolve_accept;
        logic                alarm_push;
        logic                hist_push;
        rec_t                push_rec;
        logic                start;
        logic [SRC_W-1:0]    key_src;
        logic [CODE_W-1:0]   key_code;
        logic [N_RELAY-1:0]  trig;
        logic [N_RELAY-1:0]  rel;
        logic                remote;
        logic                buzzer;
        logic                relay_a;
        logic                relay_b;
        logic                relay_aux;
    } mstate_t;

    mstate_t            s;
    mstate_t            next_s;
    logic [N_RELAY-1:0] rt_relay;

    list_if alarm_l ();
    list_if hist_l ();

    record_list u_alarm_list (
        .mclk (mclk),
        .srst (srst),
        .lst  (alarm_l.store)
    );

    record_list u_hist_list (
        .mclk (mclk),
        .srst (srst),
        .lst  (hist_l.store)
    );

    // ----------------
    // relays a, b and aux share one retrigger engine each
    // ----------------
    for (genvar g = 0; g < N_RELAY; g++) begin : g_relay
        relay_retrigger #(
            .DROP_CYCLES (DROP_CYCLES),
            .HOLD_CYCLES (HOLD_CYCLES)
        ) u_relay (
            .mclk        (mclk),
            .srst        (srst),
            .trigger     (s.trig[g]),
            .release_req (s.rel[g]),
            .relay       (rt_relay[g])
        );
    end

    // ----------------
    // control
    // ----------------
    always_comb begin
        logic               found;
        logic [DIGIT_W-1:0] d;
        logic [DIGIT_W-1:0] vd;
        found = 1'b0;
        d = '0;
        vd = digit_of(alarm_l.visit_rec.prio);
        next_s = s;
        next_s.msg_accept = '0;
        next_s.resolve_accept = 1'b0;
        next_s.alarm_push = 1'b0;
        next_s.hist_push = 1'b0;
        next_s.start = 1'b0;
        next_s.trig = '0;
        next_s.rel = '0;
        next_s.remote = 1'b0;
        if (horn_mute) begin
            next_s.buzzer = 1'b0;  // [RQ14]
            next_s.pend_census = 1'b1;  // [RQ16]
        end
        if (ack_req) begin
            next_s.pend_ack = 1'b1;
        end
        // out-of-range digits are ignored so aux never shadows relay a or b
        if (cfg_write && cfg_aux_digit >= DIGIT_AUX_MIN && cfg_aux_digit <= DIGIT_AUX_MAX) begin
            next_s.aux_mode = cfg_aux_prio_mode ? AUX_PRIO : AUX_HORN;
            next_s.aux_digit = cfg_aux_digit;
        end
        case (s.phase)
            M_IDLE: begin
                if (resolve_valid && !s.resolve_accept) begin
                    next_s.resolve_accept = 1'b1;
                    next_s.key_src = resolve_src;
                    next_s.key_code = resolve_code;
                    next_s.cur_op = OP_MARK;
                    next_s.start = 1'b1;
                    next_s.phase = M_WAIT;
                end else if (s.pend_ack) begin
                    next_s.pend_ack = ack_req;
                    next_s.cur_op = OP_COMPACT;  // alarm list only [RQ11] [RQ12]
                    next_s.start = 1'b1;
                    next_s.phase = M_WAIT;
                end else if (s.pend_census) begin
                    next_s.pend_census = horn_mute;
                    next_s.present = '0;
                    next_s.cur_op = OP_CENSUS;
                    next_s.start = 1'b1;
                    next_s.phase = M_WAIT;
                end else begin
                    for (int i = 0; i < N_SRC; i++) begin
                        if (!found && msg_valid[i] && !s.msg_accept[i]) begin  // [RQ20]
                            found = 1'b1;
                            next_s.msg_accept[i] = 1'b1;
                            next_s.push_rec = '{resolved: 1'b0, src: SRC_W'(i),
                                                prio: msg_prio[i], code: msg_code[i]};
                            d = digit_of(msg_prio[i]);  // [RQ19] [RQ4]
                            if (msg_has_prio[i]) begin  // [RQ5]
                                next_s.hist_push = 1'b1;  // [RQ3]
                                if (d != DIGIT_LOG_ONLY) begin  // [RQ6]
                                    next_s.alarm_push = 1'b1;  // [RQ3] [RQ9]
                                    next_s.remote = 1'b1;
                                    next_s.buzzer = 1'b1;  // set wins over mute [RQ13]
                                    next_s.trig[SLOT_A] = (d == DIGIT_RELAY_A);  // [RQ7]
                                    next_s.trig[SLOT_B] = (d == DIGIT_RELAY_B);  // [RQ8]
                                    next_s.trig[SLOT_AUX] = (s.aux_mode == AUX_PRIO)
                                                            && (d == s.aux_digit);  // [RQ9]
                                end
                            end
                        end
                    end
                end
            end
            M_WAIT: begin
                if (alarm_l.visit && s.cur_op == OP_CENSUS) begin
                    next_s.present[vd] = 1'b1;
                end
                if (alarm_l.done) begin
                    next_s.phase = M_IDLE;
                    if (s.cur_op == OP_CENSUS) begin
                        next_s.rel[SLOT_A] = !next_s.present[DIGIT_RELAY_A];  // [RQ16]
                        next_s.rel[SLOT_B] = !next_s.present[DIGIT_RELAY_B];  // [RQ16]
                        next_s.rel[SLOT_AUX] = !next_s.present[s.aux_digit];
                    end
                end
            end
            default: begin
                next_s.phase = M_IDLE;
            end
        endcase
        next_s.relay_a = rt_relay[SLOT_A];
        next_s.relay_b = rt_relay[SLOT_B];
        // horn mode: contact mirrors buzzer on the same edge [RQ18] [RQ13]
        next_s.relay_aux = (next_s.aux_mode == AUX_HORN) ? next_s.buzzer : rt_relay[SLOT_AUX];
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            s <= '0;
            s.aux_mode <= AUX_MODE_RESET;  // [RQ10]
            s.aux_digit <= AUX_DIGIT_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ----------------
    // list wiring and outputs
    // ----------------
    assign alarm_l.push = s.alarm_push;
    assign alarm_l.push_rec = s.push_rec;
    assign alarm_l.start = s.start;
    assign alarm_l.op = s.cur_op;
    assign alarm_l.key_src = s.key_src;
    assign alarm_l.key_code = s.key_code;
    assign alarm_l.rd_idx = alarm_rd_idx;
    assign hist_l.push = s.hist_push;
    assign hist_l.push_rec = s.push_rec;
    assign hist_l.start = 1'b0;  // history is never swept [RQ12]
    assign hist_l.op = OP_NONE;
    assign hist_l.key_src = '0;
    assign hist_l.key_code = '0;
    assign hist_l.rd_idx = hist_rd_idx;

    assign msg_accept = s.msg_accept;
    assign resolve_accept = s.resolve_accept;
    assign alarm_rd_rec = alarm_l.rd_rec;
    assign alarm_count = alarm_l.count;
    assign hist_rd_rec = hist_l.rd_rec;
    assign hist_count = hist_l.count;
    assign busy = (s.phase == M_WAIT);
    assign remote_alarm = s.remote;
    assign buzzer = s.buzzer;
    assign high_alarm_relay_a = s.relay_a;
    assign high_alarm_relay_b = s.relay_b;
    assign aux_relay = s.relay_aux;
    assign aux_prio_mode = (s.aux_mode == AUX_PRIO);
    assign aux_decade_select = s.aux_digit;

endmodule : alarm_priority_router
`default_nettype wire

// [bench/field_source.sv]
// model of the field controllers offering messages
`timescale 1ns/1ps
`default_nettype none
module field_source (
    input  wire logic       mclk,
    input  wire logic       srst,
    input  wire logic [3:0] send,
    input  wire logic [3:0] accept,
    output var  logic [3:0] valid
);
    // a controller keeps offering until the centre answers
    always_ff @(posedge mclk) valid <= srst ? 4'h0 : (valid | send) & ~accept;
endmodule : field_source
`default_nettype wire

// [bench/alarm_priority_router_monitor.sv]
// port assertions of the alarm priority router
`timescale 1ns/1ps
`default_nettype none
module alarm_checker
    import alarm_pkg::*;
(
    input wire logic                           mclk,
    input wire logic                           srst,
    input wire logic [N_SRC-1:0]               msg_has_prio,
    input wire logic [N_SRC-1:0][PRIO_W-1:0]   msg_prio,
    input wire logic [N_SRC-1:0]               msg_accept,
    input wire logic                           horn_mute,
    input wire logic                           remote_alarm,
    input wire logic                           buzzer,
    input wire logic                           aux_relay,
    input wire logic                           aux_prio_mode,
    input wire logic [DIGIT_W-1:0]             aux_decade_select,
    input wire logic [CNT_W-1:0]               alarm_count,
    input wire logic [CNT_W-1:0]               hist_count
);
    // ----
    // checks
    // ----
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    sequence s_mute;
        horn_mute ##1 !remote_alarm;
    endsequence
    chk_reset_aux: assert property ($past(srst) |-> aux_decade_select == 4'h3 && !aux_prio_mode)
        else $error("aux not reset");
    chk_one_taken: assert property ($onehot0(msg_accept))
        else $error("two taken at once");
    chk_take_pulse: assert property (msg_accept[0] |=> !msg_accept[0])
        else $error("accept too long");
    chk_alarm_digit: assert property (msg_accept[0] |->
        remote_alarm == (msg_has_prio[0] && msg_prio[0] % 7'h0A != 7'h00))
        else $error("alarm vs digit");
    chk_alarm_buzz: assert property (remote_alarm |-> buzzer)
        else $error("no buzzer on alarm");
    chk_mute_off: assert property (s_mute |-> !buzzer)
        else $error("buzzer on after mute");
    chk_horn_follow: assert property (!aux_prio_mode |-> aux_relay == buzzer)
        else $error("horn not buzzer");
    chk_hist_kept: assert property (hist_count >= $past(hist_count))
        else $error("history shrank");
    chk_alarm_step: assert property (alarm_count <= $past(alarm_count) + 1)
        else $error("alarm list jump");
    chk_list_cap: assert property (hist_count <= 1000 && alarm_count <= hist_count)
        else $error("count out of range");
endmodule : alarm_checker
bind alarm_priority_router alarm_checker chk_i (.*);
`default_nettype wire

// [bench/test_alarm_priority_router.sv]
// self-checking bench of the alarm priority router
`timescale 1ns/1ps
`default_nettype none
module test_alarm_priority_router;
    import alarm_pkg::*;
    logic mclk, srst, ack_req, horn_mute, resolve_valid, resolve_accept, busy, remote_alarm;
    logic buzzer, high_alarm_relay_a, high_alarm_relay_b, aux_relay, aux_prio_mode;
    logic [N_SRC-1:0] send, msg_valid, msg_has_prio, msg_accept;
    logic [N_SRC-1:0][PRIO_W-1:0] msg_prio;
    logic [N_SRC-1:0][CODE_W-1:0] msg_code;
    logic [DIGIT_W-1:0] aux_decade_select, cfg_aux_digit;
    logic cfg_write, cfg_aux_prio_mode;
    logic [CNT_W-1:0] alarm_count, hist_count;
    logic [IDX_W-1:0] rd_idx;
    rec_t alarm_rd_rec, hist_rd_rec;
    int fails = 0;
    int n_tests = 0;
    // short drop and hold so a retrigger fits the run
    alarm_priority_router #(.DROP_CYCLES(20), .HOLD_CYCLES(100)) uut (.mclk, .srst, .msg_valid,
        .msg_has_prio, .msg_prio, .msg_code, .msg_accept, .resolve_valid, .resolve_src(2'h1),
        .resolve_code(8'h11), .resolve_accept, .ack_req, .horn_mute, .cfg_write,
        .cfg_aux_prio_mode, .cfg_aux_digit, .alarm_rd_idx(rd_idx), .alarm_rd_rec,
        .alarm_count, .hist_rd_idx(rd_idx), .hist_rd_rec, .hist_count, .busy, .remote_alarm,
        .buzzer, .high_alarm_relay_a, .high_alarm_relay_b, .aux_relay, .aux_prio_mode,
        .aux_decade_select);
    field_source src_i (.mclk, .srst, .send, .accept(msg_accept), .valid(msg_valid));
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize
    task automatic cmp(input logic [CNT_W:0] exp, input logic [CNT_W:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: expected %0h got %0h", $time, exp, got);
        end
    endtask : cmp
    task automatic post(input int s, input logic hp, input logic [PRIO_W-1:0] p);
        msg_has_prio[s] = hp;
        msg_prio[s] = p;
        send[s] = 1'b1;
    endtask : post
    // bounded wait for idle
    task automatic settle;
        int k;
        @(negedge mclk);
        {send, ack_req, horn_mute, cfg_write} = '0;
        @(negedge mclk);
        for (k = 0; k < 5000; k++) begin
            if (resolve_accept === 1'b1) resolve_valid = 1'b0;
            if (msg_valid == 0 && busy === 1'b0 && !resolve_valid) break;
            @(negedge mclk);
        end
        if (k == 5000) begin
            fails++;
            summarize();
        end
        repeat (4) @(negedge mclk);
    endtask : settle
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        {cfg_write, send, msg_has_prio, msg_prio, ack_req, horn_mute, resolve_valid, rd_idx} = '0;
        srst = 1'b1;
        msg_code = {8'h33, 8'h22, 8'h11, 8'h00};
        repeat (10) @(negedge mclk);
        srst = 1'b0;
        cmp(3, aux_decade_select);
        cmp(0, aux_prio_mode);
        post(0, 1'b1, 7'd40);
        settle();
        post(0, 1'b0, 7'd5);
        settle();
        cmp(1, hist_count);
        cmp(0, {alarm_count, buzzer});
        $display("test log only done");
        post(1, 1'b1, 7'd91);
        post(2, 1'b1, 7'd12);
        post(3, 1'b1, 7'd25);
        settle();
        cmp(3, alarm_count);
        cmp(4, hist_count);
        cmp(4'hF, {high_alarm_relay_a, high_alarm_relay_b, buzzer, aux_relay});
        cmp(91, alarm_rd_rec.prio);
        $display("test alarms done");
        horn_mute = 1'b1;
        settle();
        cmp(4'h3, {buzzer, aux_relay, high_alarm_relay_a, high_alarm_relay_b});
        ack_req = 1'b1;
        settle();
        cmp(3, alarm_count);
        resolve_valid = 1'b1;
        settle();
        ack_req = 1'b1;
        settle();
        cmp(2, alarm_count);
        cmp(4, hist_count);
        cmp(12, alarm_rd_rec.prio);
        horn_mute = 1'b1;
        settle();
        cmp(1, {high_alarm_relay_a, high_alarm_relay_b});
        $display("test mute and acknowledge done");
        for (int i = 0; i < 1002; i++) begin
            post(0, 1'b1, 7'((i % 10) * 10));
            settle();
        end
        cmp(1000, hist_count);
        cmp(20, hist_rd_rec.prio);
        cmp(2, alarm_count);
        $display("test full history done");
        cfg_write = 1'b1;
        {cfg_aux_prio_mode, cfg_aux_digit} = 5'h15;
        post(0, 1'b1, 7'd2);
        post(1, 1'b1, 7'd15);
        settle();
        cmp(0, high_alarm_relay_b);
        cmp(5, aux_decade_select);
        cmp(1, aux_relay);
        repeat (30) @(negedge mclk);
        cmp(1, high_alarm_relay_b);
        $display("test retrigger and aux done");
        summarize();
    end
endmodule : test_alarm_priority_router
`default_nettype wire
